// ===== verilog/tdtg_pkg.sv
// shared constants, types and decoders for the dual sine tone generator
package tdtg_pkg;
  localparam logic [7:0] ADDR_CTRL_ONE = 8'hA0;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'hA1;
  localparam logic [7:0] ADDR_A_LOW = 8'hA2;
  localparam logic [7:0] ADDR_A_HIGH = 8'hA3;
  localparam logic [7:0] ADDR_B_LOW = 8'hA4;
  localparam logic [7:0] ADDR_B_HIGH = 8'hA5;
  localparam logic [7:0] ADDR_REPEAT = 8'hA6;
  localparam logic [7:0] ADDR_ON = 8'hA7;
  localparam logic [7:0] ADDR_OFF = 8'hA8;

  localparam int RUN_BIT = 7;
  localparam int KEYMODE_BIT = 4;
  localparam int KEY_MSB = 3;
  localparam int SEL_MSB = 1;
  localparam int REPEAT_MSB = 2;
  localparam int PER_MSB = 5;

  localparam logic RST_RUN = 1'h0;
  localparam logic RST_KEYMODE = 1'h0;
  localparam logic [3:0] RST_KEY = 4'h0;
  localparam logic [1:0] RST_SEL = 2'h0;
  localparam logic [7:0] RST_A_LOW = 8'h55;
  localparam logic [7:0] RST_A_HIGH = 8'h15;
  localparam logic [7:0] RST_B_LOW = 8'h00;
  localparam logic [7:0] RST_B_HIGH = 8'h40;
  localparam logic [2:0] RST_REPEAT = 3'h0;
  localparam logic [5:0] RST_ON = 6'h02;
  localparam logic [5:0] RST_OFF = 6'h01;

  localparam logic [1:0] SEL_SUM = 2'h0;
  localparam logic [1:0] SEL_A = 2'h1;
  localparam logic [1:0] SEL_B = 2'h2;
  localparam logic [1:0] SEL_RAMP = 2'h3;

  localparam logic [5:0] PER_CONT = 6'h3F;
  localparam logic [5:0] PER_FINE_MAX = 6'h14;
  localparam logic [5:0] PER_COARSE_MIN = 6'h19;
  localparam logic [5:0] PER_COARSE_MAX = 6'h3C;
  localparam int FINE_STEP_MS = 10;
  localparam int COARSE_BASE_MS = 250;
  localparam int COARSE_STEP_MS = 50;
  localparam logic [2:0] REPEAT_FOREVER = 3'h7;

  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_TIME_NS = 1000000;
  localparam int MS_CYCLES_DEF = MS_TIME_NS / CLK_PERIOD_NS;
  localparam logic [15:0] QUARTER_PHASE = 16'h4000;
  localparam logic [14:0] SINE_PEAK = 15'h7FFF;
  localparam logic signed [16:0] RAMP_TOP = 17'sh07FFF;

  localparam logic [14:0] SINE_QUARTER [32] = '{
    15'h0000, 15'h0648, 15'h0C8C, 15'h12C8, 15'h18F9, 15'h1F1A, 15'h2528,
    15'h2B1F, 15'h30FB, 15'h36BA, 15'h3C56, 15'h41CE, 15'h471C, 15'h4C3F,
    15'h5133, 15'h55F5, 15'h5A82, 15'h5ED7, 15'h62F2, 15'h66CF, 15'h6A6D,
    15'h6DC9, 15'h70E2, 15'h73B5, 15'h7641, 15'h7884, 15'h7A7C, 15'h7C29,
    15'h7D89, 15'h7E9C, 15'h7F61, 15'h7FD8};
  // keypad step words for the 12 kHz sample family
  localparam logic [15:0] KEY_ROW_STEP [4] = '{
    16'h0EDE, 16'h106C, 16'h122C, 16'h1412};
  localparam logic [15:0] KEY_COL_STEP [4] = '{
    16'h19CA, 16'h1C7F, 16'h1F81, 16'h22D5};

  typedef enum logic [2:0] {
    TDTG_IDLE = 3'b001,
    TDTG_ON = 3'b010,
    TDTG_OFF = 3'b100
  } tdtg_state_t;

  typedef struct packed {
    logic wrEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } tdtg_reg_req_t;

  typedef struct packed {
    logic valid;
    logic signed [15:0] data;
  } tdtg_sample_t;

  function automatic logic [11:0] tdtgPeriodMs(input logic [5:0] code);
    if (code != 6'h00 && code <= PER_FINE_MAX) begin
      tdtgPeriodMs = 12'(int'(code) * FINE_STEP_MS);
    end else if (code >= PER_COARSE_MIN && code <= PER_COARSE_MAX) begin
      tdtgPeriodMs = 12'(COARSE_BASE_MS +
        (int'(code) - int'(PER_COARSE_MIN)) * COARSE_STEP_MS);
    end else begin
      tdtgPeriodMs = 12'(FINE_STEP_MS);
    end
  endfunction

  function automatic logic [5:0] tdtgRepeatTarget(input logic [2:0] code);
    case (code)
      3'h0: tdtgRepeatTarget = 6'h01;
      3'h1: tdtgRepeatTarget = 6'h02;
      3'h2: tdtgRepeatTarget = 6'h03;
      3'h3: tdtgRepeatTarget = 6'h04;
      3'h4: tdtgRepeatTarget = 6'h08;
      3'h5: tdtgRepeatTarget = 6'h10;
      3'h6: tdtgRepeatTarget = 6'h20;
      default: tdtgRepeatTarget = 6'h00;
    endcase
  endfunction

  function automatic logic [1:0] tdtgKeyRow(input logic [3:0] k);
    if (k == 4'h0 || k >= 4'hE) begin
      tdtgKeyRow = 2'h3;
    end else if (k >= 4'hA) begin
      tdtgKeyRow = 2'(k - 4'hA);
    end else begin
      tdtgKeyRow = 2'((k - 4'h1) / 4'h3);
    end
  endfunction

  function automatic logic [1:0] tdtgKeyCol(input logic [3:0] k);
    if (k == 4'h0) begin
      tdtgKeyCol = 2'h1;
    end else if (k == 4'hE) begin
      tdtgKeyCol = 2'h0;
    end else if (k == 4'hF) begin
      tdtgKeyCol = 2'h2;
    end else if (k >= 4'hA) begin
      tdtgKeyCol = 2'h3;
    end else begin
      tdtgKeyCol = 2'((k - 4'h1) % 4'h3);
    end
  endfunction
endpackage

// ===== verilog/tdtg_sine_rom.sv
// quarter-wave sine lookup with registered output
`timescale 1ns/1ps
module tdtg_sine_rom
  import tdtg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [15:0] phase,
  output logic signed [15:0] sine
);
  typedef struct packed {
    logic signed [15:0] sine;
  } tdtg_rom_t;

  tdtg_rom_t s_r;
  tdtg_rom_t s_nxt;

  always_comb begin
    logic [4:0] idx;
    logic [14:0] mag;
    idx = phase[13:9];
    mag = SINE_QUARTER[idx];
    s_nxt = s_r;
    // falling quarters read the table mirrored, peak at the fold
    if (phase[14]) begin
      mag = (idx == 5'h00) ? SINE_PEAK : SINE_QUARTER[5'(-idx)];
    end
    s_nxt.sine = phase[15] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sine = s_r.sine;
endmodule

// ===== verilog/tdtg_burst_timer.sv
// millisecond down-counter for burst on and off periods
`timescale 1ns/1ps
module tdtg_burst_timer
  import tdtg_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic load,
  input wire logic [11:0] loadMs,
  output logic expired
);
  localparam int PW = $clog2(MS_CYCLES + 1);

  typedef struct packed {
    logic [PW-1:0] pre;
    logic [11:0] remain;
    logic busy;
  } tdtg_tmr_t;

  tdtg_tmr_t s_r;
  tdtg_tmr_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (load) begin
      s_nxt.pre = '0;
      s_nxt.remain = loadMs;
      s_nxt.busy = 1'b1;
    end else if (s_r.busy) begin
      if (s_r.pre == PW'(MS_CYCLES - 1)) begin
        s_nxt.pre = '0;
        s_nxt.remain = s_r.remain - 12'h001;
        if (s_r.remain <= 12'h001) begin
          s_nxt.busy = 1'b0;
        end
      end else begin
        s_nxt.pre = s_r.pre + PW'(1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // flagged in the last cycle so a reload lands exactly one period on
  assign expired = s_r.busy && (s_r.pre == PW'(MS_CYCLES - 1)) &&
    (s_r.remain <= 12'h001);
endmodule

// ===== verilog/tdtg_tone_gen.sv
// dual sine tone generator with keypad tones and counted bursts
`timescale 1ns/1ps
module tdtg_tone_gen
  import tdtg_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire tdtg_reg_req_t regReq,
  input wire logic sampleTick,
  output logic [7:0] regRdData,
  output tdtg_sample_t toneOut,
  output logic toneActive
);
  typedef struct packed {
    logic run;
    logic keyMode;
    logic [3:0] key;
    logic [1:0] sel;
    logic [7:0] aLow;
    logic [7:0] aHigh;
    logic [7:0] bLow;
    logic [7:0] bHigh;
    logic [2:0] repeatCode;
    logic [5:0] onPer;
    logic [5:0] offPer;
    tdtg_state_t state;
    logic [5:0] cycDone;
    logic [15:0] phaseA;
    logic [15:0] phaseB;
    logic tickD1;
    logic signed [15:0] sample;
    logic valid;
    logic active;
    logic [7:0] rdData;
  } tdtg_core_t;

  tdtg_core_t s_r;
  tdtg_core_t s_nxt;

  logic signed [15:0] sineA;
  logic signed [15:0] sineB;
  logic [15:0] romAddrA;
  logic tmrLoad;
  logic [11:0] tmrMs;
  logic tmrExpired;

  function automatic logic addrHit(input tdtg_reg_req_t req,
                                   input logic [7:0] addr);
    addrHit = req.wrEn && (req.addr == addr);
  endfunction

  // in ramp mode the first lookup is shifted a quarter turn to give cos
  always_comb begin
    if (s_r.sel == SEL_RAMP) begin
      romAddrA = s_r.phaseA + QUARTER_PHASE;
    end else begin
      romAddrA = s_r.phaseA;
    end
  end

  tdtg_sine_rom u_rom_a (
    .clk_sys(clk_sys),
    .rst(rst),
    .phase(romAddrA),
    .sine(sineA)
  );

  tdtg_sine_rom u_rom_b (
    .clk_sys(clk_sys),
    .rst(rst),
    .phase(s_r.phaseB),
    .sine(sineB)
  );

  tdtg_burst_timer #(
    .MS_CYCLES(MS_CYCLES)
  ) u_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .load(tmrLoad),
    .loadMs(tmrMs),
    .expired(tmrExpired)
  );

  always_comb begin
    logic [15:0] stepA;
    logic [15:0] stepB;
    logic signed [16:0] sumAB;
    logic signed [16:0] ramp;
    logic signed [15:0] mixed;
    logic onCont;
    logic offCont;
    logic startReq;
    logic zeroCross;
    logic [5:0] target;
    logic [5:0] doneNext;
    stepA = {s_r.aHigh, s_r.aLow};
    stepB = {s_r.bHigh, s_r.bLow};
    sumAB = 17'(sineA) + 17'(sineB);
    ramp = RAMP_TOP - 17'(sineA);
    mixed = '0;
    onCont = (s_r.onPer == PER_CONT);
    offCont = (s_r.offPer == PER_CONT);
    startReq = addrHit(regReq, ADDR_CTRL_ONE) && regReq.wrData[RUN_BIT];
    zeroCross = 1'b0;
    target = tdtgRepeatTarget(s_r.repeatCode);
    doneNext = s_r.cycDone + 6'h01;
    tmrLoad = 1'b0;
    tmrMs = tdtgPeriodMs(s_r.onPer);
    s_nxt = s_r;
    s_nxt.valid = 1'b0;
    s_nxt.tickD1 = sampleTick;

    // keypad mode replaces both step words with the key's tone pair
    if (s_r.keyMode) begin
      stepA = KEY_ROW_STEP[tdtgKeyRow(s_r.key)];
      stepB = KEY_COL_STEP[tdtgKeyCol(s_r.key)];
    end

    // register writes
    if (addrHit(regReq, ADDR_CTRL_ONE)) begin
      s_nxt.run = regReq.wrData[RUN_BIT];
      s_nxt.keyMode = regReq.wrData[KEYMODE_BIT];
      s_nxt.key = regReq.wrData[KEY_MSB:0];
    end else if (addrHit(regReq, ADDR_CTRL_TWO)) begin
      s_nxt.sel = regReq.wrData[SEL_MSB:0];
    end else if (addrHit(regReq, ADDR_A_LOW)) begin
      s_nxt.aLow = regReq.wrData;
    end else if (addrHit(regReq, ADDR_A_HIGH)) begin
      s_nxt.aHigh = regReq.wrData;
    end else if (addrHit(regReq, ADDR_B_LOW)) begin
      s_nxt.bLow = regReq.wrData;
    end else if (addrHit(regReq, ADDR_B_HIGH)) begin
      s_nxt.bHigh = regReq.wrData;
    end else if (addrHit(regReq, ADDR_REPEAT)) begin
      s_nxt.repeatCode = regReq.wrData[REPEAT_MSB:0];
    end else if (addrHit(regReq, ADDR_ON)) begin
      s_nxt.onPer = regReq.wrData[PER_MSB:0];
    end else if (addrHit(regReq, ADDR_OFF)) begin
      s_nxt.offPer = regReq.wrData[PER_MSB:0];
    end

    // output selector
    case (s_r.sel)
      SEL_SUM: mixed = sumAB[16:1];
      SEL_A: mixed = sineA;
      SEL_B: mixed = sineB;
      default: mixed = ramp[16:1];
    endcase
    if (s_r.state != TDTG_ON) begin
      mixed = '0;
    end

    // new sample one cycle after the tick, taken from the lookup of the phase before it advanced
    if (s_r.tickD1) begin
      s_nxt.sample = mixed;
      s_nxt.valid = 1'b1;
      zeroCross = (mixed == 16'sh0000) || (mixed[15] != s_r.sample[15]);
    end

    // burst sequencer
    case (s_r.state)
      TDTG_IDLE: begin
        if (startReq) begin
          s_nxt.state = TDTG_ON;
          s_nxt.cycDone = '0;
          s_nxt.phaseA = '0;
          s_nxt.phaseB = '0;
          tmrLoad = !onCont;
        end
      end
      TDTG_ON: begin
        if (sampleTick) begin
          s_nxt.phaseA = s_r.phaseA + stepA;
          s_nxt.phaseB = s_r.phaseB + stepB;
        end
        if (onCont) begin
          if (!s_r.run && s_r.tickD1 && zeroCross) begin
            s_nxt.state = TDTG_IDLE;
          end
        end else if (tmrExpired) begin
          s_nxt.state = TDTG_OFF;
          tmrMs = tdtgPeriodMs(s_r.offPer);
          tmrLoad = !offCont;
        end
      end
      TDTG_OFF: begin
        if (offCont) begin
          if (!s_r.run) begin
            s_nxt.state = TDTG_IDLE;
          end
        end else if (tmrExpired) begin
          s_nxt.cycDone = doneNext;
          if (target != 6'h00 && doneNext >= target) begin
            s_nxt.state = TDTG_IDLE;
            // a run write in this same cycle keeps its value
            if (!addrHit(regReq, ADDR_CTRL_ONE)) begin
              s_nxt.run = 1'b0;
            end
          end else if (!s_r.run) begin
            s_nxt.state = TDTG_IDLE;
          end else begin
            s_nxt.state = TDTG_ON;
            tmrLoad = !onCont;
          end
        end
      end
      default: begin
        s_nxt.state = TDTG_IDLE;
      end
    endcase

    s_nxt.active = (s_nxt.state != TDTG_IDLE);

    // read data, one cycle after the address
    if (regReq.addr == ADDR_CTRL_ONE) begin
      s_nxt.rdData = {s_r.run, 2'h0, s_r.keyMode, s_r.key};
    end else if (regReq.addr == ADDR_CTRL_TWO) begin
      s_nxt.rdData = {6'h00, s_r.sel};
    end else if (regReq.addr == ADDR_A_LOW) begin
      s_nxt.rdData = s_r.aLow;
    end else if (regReq.addr == ADDR_A_HIGH) begin
      s_nxt.rdData = s_r.aHigh;
    end else if (regReq.addr == ADDR_B_LOW) begin
      s_nxt.rdData = s_r.bLow;
    end else if (regReq.addr == ADDR_B_HIGH) begin
      s_nxt.rdData = s_r.bHigh;
    end else if (regReq.addr == ADDR_REPEAT) begin
      s_nxt.rdData = {5'h00, s_r.repeatCode};
    end else if (regReq.addr == ADDR_ON) begin
      s_nxt.rdData = {2'h0, s_r.onPer};
    end else if (regReq.addr == ADDR_OFF) begin
      s_nxt.rdData = {2'h0, s_r.offPer};
    end else begin
      s_nxt.rdData = 8'h00;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_r <= '0;
      s_r.run <= RST_RUN;
      s_r.keyMode <= RST_KEYMODE;
      s_r.key <= RST_KEY;
      s_r.sel <= RST_SEL;
      s_r.aLow <= RST_A_LOW;
      s_r.aHigh <= RST_A_HIGH;
      s_r.bLow <= RST_B_LOW;
      s_r.bHigh <= RST_B_HIGH;
      s_r.repeatCode <= RST_REPEAT;
      s_r.onPer <= RST_ON;
      s_r.offPer <= RST_OFF;
      s_r.state <= TDTG_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign regRdData = s_r.rdData;
  assign toneOut.valid = s_r.valid;
  assign toneOut.data = s_r.sample;
  assign toneActive = s_r.active;
endmodule

// ===== verification/tdtg_monitor.sv
// port-level checker for the dual sine tone generator
`timescale 1ns/1ps
module tdtg_monitor
  import tdtg_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  input wire logic clk_sys,
  input wire logic rst,
  input tdtg_reg_req_t regReq,
  input wire logic sampleTick,
  input wire logic [7:0] regRdData,
  input tdtg_sample_t toneOut,
  input wire logic toneActive
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // cycles the sequencer has been idle, saturating
  logic [2:0] idleCnt;
  always_ff @(posedge clk_sys) begin
    if (rst || toneActive) begin
      idleCnt <= 3'h0;
    end else if (idleCnt != 3'h7) begin
      idleCnt <= idleCnt + 3'h1;
    end
  end

  a_tick_gives_valid: assert property (sampleTick |-> ##2 toneOut.valid)
    else $error("sample missing two cycles after tick");
  a_valid_needs_tick: assert property (
    toneOut.valid |-> $past(sampleTick, 2))
    else $error("sample without a tick");
  a_write_starts: assert property (regReq.wrEn && regReq.addr == ADDR_CTRL_ONE
    && regReq.wrData[7] && !toneActive |=> toneActive)
    else $error("run write did not start tone");
  a_start_cause: assert property ($rose(toneActive) |->
    $past(regReq.wrEn) && $past(regReq.addr) == ADDR_CTRL_ONE)
    else $error("tone started without run write");
  a_active_min: assert property ($rose(toneActive) |-> toneActive[*8])
    else $error("burst ended too early");
  a_run_clears: assert property ($fell(toneActive) && !regReq.wrEn
    && regReq.addr == ADDR_CTRL_ONE |=> !regRdData[7])
    else $error("run bit not cleared at end");
  a_sel_readback: assert property (regReq.wrEn && regReq.addr == ADDR_CTRL_TWO
    ##1 !regReq.wrEn && regReq.addr == ADDR_CTRL_TWO
    |=> regRdData == ($past(regReq.wrData, 2) & 8'h03))
    else $error("selector readback wrong");
  a_reserved_zero: assert property ((regReq.addr == ADDR_CTRL_ONE
    |=> regRdData[6:5] == 2'h0) and (regReq.addr == ADDR_REPEAT
    |=> regRdData[7:3] == 5'h00))
    else $error("reserved bits not zero");
  a_unmapped_zero: assert property ((regReq.addr < ADDR_CTRL_ONE
    || regReq.addr > ADDR_OFF) |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  a_idle_silent: assert property (toneOut.valid && idleCnt >= 3'h4
    |-> toneOut.data == 16'sh0000)
    else $error("sample not zero while idle");
endmodule

bind tdtg_tone_gen tdtg_monitor #(.MS_CYCLES(MS_CYCLES)) mon_u (
  .clk_sys(clk_sys), .rst(rst), .regReq(regReq), .sampleTick(sampleTick),
  .regRdData(regRdData), .toneOut(toneOut), .toneActive(toneActive));

// ===== verification/tdtg_mixer_model.sv
// mixer-side model: paces sample ticks and captures the first eight samples
`timescale 1ns/1ps
module tdtg_mixer_model
  import tdtg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic tickEn,
  input wire logic [3:0] gapLen,
  input tdtg_sample_t toneOut,
  output logic sampleTick,
  output logic [3:0] capCount,
  output logic signed [15:0] capData [8]
);
  logic [3:0] gap;
  // gap 0 ticks every cycle, larger gaps model a slow mixer
  always_ff @(posedge clk_sys) begin
    if (rst || !tickEn) begin
      gap <= 4'h0;
      sampleTick <= 1'b0;
      capCount <= 4'h0;
    end else begin
      sampleTick <= (gap == 4'h0);
      gap <= (gap == 4'h0) ? gapLen : gap - 4'h1;
      if (toneOut.valid && capCount != 4'h8) begin
        capData[capCount[2:0]] <= toneOut.data;
        capCount <= capCount + 4'h1;
      end
    end
  end
endmodule

// ===== verification/tb_top.sv
// self-checking testbench for the dual sine tone generator
`timescale 1ns/1ps
`define CHK(g, e) begin totalChecks++; if ((g) !== (e)) begin numErrors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top
  import tdtg_pkg::*;
;
  localparam int MSC = 10;
  localparam logic [7:0] RSTV [10] = '{8'h00, 8'h00, 8'h55, 8'h15, 8'h00,
    8'h40, 8'h00, 8'h02, 8'h01, 8'h00};
  localparam logic [7:0] MSK [10] = '{8'h9F, 8'h03, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'h07, 8'h3F, 8'h3F, 8'h00};
  localparam int REPS [5] = '{1, 2, 3, 4, 32};
  localparam logic [2:0] RCODE [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
  logic clk_sys, rst, sampleTick, toneActive, tickEn;
  logic [3:0] gapLen, capCount;
  logic [7:0] regRdData, d, r;
  logic [15:0] a, b;
  tdtg_reg_req_t regReq;
  tdtg_sample_t toneOut;
  logic signed [15:0] capData [8];
  logic signed [15:0] qa [8], qb [8], qs [8];
  int numErrors, totalChecks, seed;

  tdtg_tone_gen #(.MS_CYCLES(MSC)) dut_u (.clk_sys(clk_sys), .rst(rst),
    .regReq(regReq), .sampleTick(sampleTick), .regRdData(regRdData),
    .toneOut(toneOut), .toneActive(toneActive));
  tdtg_mixer_model mix_u (.clk_sys(clk_sys), .rst(rst), .tickEn(tickEn),
    .gapLen(gapLen), .toneOut(toneOut), .sampleTick(sampleTick),
    .capCount(capCount), .capData(capData));

  function automatic int perC(int c);
    return (c <= 20) ? c * 10 * MSC : (250 + (c - 25) * 50) * MSC;
  endfunction
  function automatic int keyRow(int k);
    if (k == 0 || k >= 14) return 3;
    if (k >= 10) return k - 10;
    return (k - 1) / 3;
  endfunction
  function automatic int keyCol(int k);
    if (k == 0) return 1;
    if (k == 14) return 0;
    if (k == 15) return 2;
    if (k >= 10) return 3;
    return (k - 1) % 3;
  endfunction

  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    @(posedge clk_sys);
    regReq <= '{1'b1, ad, dt};
    @(posedge clk_sys);
    regReq.wrEn <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [7:0] dt);
    @(posedge clk_sys);
    regReq.addr <= ad;
    repeat (2) @(posedge clk_sys);
    #1 dt = regRdData;
  endtask
  task automatic burst(input logic [2:0] rep, input logic [5:0] on, off,
      input int stopAt, input int ex);
    int n = 0;
    wr(ADDR_REPEAT, {5'h0, rep});
    wr(ADDR_ON, {2'h0, on});
    wr(ADDR_OFF, {2'h0, off});
    wr(ADDR_CTRL_ONE, 8'h80);
    if (stopAt > 0) begin
      repeat (stopAt) @(posedge clk_sys);
      wr(ADDR_CTRL_ONE, 8'h00);
      n = stopAt + 2;
    end
    #1;
    while (toneActive === 1'b1 && n < 20000) begin
      @(posedge clk_sys);
      #1 n++;
    end
    `CHK(n > ex - 4 && n < ex + 4, 1'b1)
    rd(ADDR_CTRL_ONE, d);
    `CHK(d[7], 1'b0)
  endtask
  // continuous tone, capture eight samples, then stop
  task automatic tone(input logic [7:0] c1, input logic [1:0] sel,
      input logic [15:0] sa, sb, output logic signed [15:0] q [8]);
    int n = 0;
    wr(ADDR_CTRL_TWO, {6'h0, sel});
    wr(ADDR_A_LOW, sa[7:0]);
    wr(ADDR_A_HIGH, sa[15:8]);
    wr(ADDR_B_LOW, sb[7:0]);
    wr(ADDR_B_HIGH, sb[15:8]);
    wr(ADDR_ON, 8'h3F);
    wr(ADDR_CTRL_ONE, c1 | 8'h80);
    @(posedge clk_sys);
    gapLen <= 4'($random(seed) & 7);
    tickEn <= 1'b1;
    while (capCount !== 4'h8 && n < 500) begin
      @(posedge clk_sys);
      #1 n++;
    end
    `CHK(capCount, 4'h8)
    q = capData;
    wr(ADDR_CTRL_ONE, c1);
    n = 0;
    #1;
    while (toneActive === 1'b1 && n < 3000) begin
      @(posedge clk_sys);
      #1 n++;
    end
    `CHK(toneActive, 1'b0)
    @(posedge clk_sys);
    tickEn <= 1'b0;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    numErrors++;
    results();
  end

  initial begin
    seed = 54;
    numErrors = 0;
    totalChecks = 0;
    rst = 1'b1;
    regReq = '0;
    tickEn = 1'b0;
    gapLen = 4'h0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      rd(8'(8'hA0 + i), d);
      `CHK(d, RSTV[i])
    end
    for (int i = 0; i < 10; i++) begin
      r = 8'($random(seed));
      if (i == 0) r = r & 8'h7F;
      wr(8'(8'hA0 + i), r);
      rd(8'(8'hA0 + i), d);
      `CHK(d, r & MSK[i])
    end
    $display("test registers done");
    a = 16'((65536 * (200 + ($random(seed) & 2047))) / 12000 - 1);
    b = 16'((65536 * (200 + ($random(seed) & 2047))) / 11025 - 1);
    tone(8'h00, SEL_A, a, b, qa);
    tone(8'h00, SEL_B, b, a, qb);
    tone(8'h00, SEL_SUM, a, a, qs);
    for (int i = 0; i < 8; i++) begin
      `CHK(qb[i], qa[i])
      `CHK(qs[i], qa[i])
    end
    tone(8'h00, SEL_RAMP, a, b, qs);
    for (int i = 0; i < 8; i++) `CHK(qs[i][15], 1'b0)
    $display("test selector done");
    for (int k = 0; k < 16; k++) begin
      tone(8'h10 | 8'(k), SEL_SUM, a, b, qa);
      tone(8'(k), SEL_SUM, KEY_ROW_STEP[keyRow(k)],
        KEY_COL_STEP[keyCol(k)], qb);
      for (int i = 0; i < 8; i++) `CHK(qa[i], qb[i])
    end
    $display("test keypad done");
    for (int i = 0; i < 5; i++) begin
      burst(RCODE[i], 6'h01, 6'h01, 0, REPS[i] * 2 * perC(1));
    end
    burst(3'h0, 6'h19, 6'h02, 0, perC(25) + perC(2));
    burst(3'h7, 6'h01, 6'h01, 250, 4 * perC(1));
    $display("test bursts done");
    results();
  end
endmodule
